/* logic/dtb_params.svh */
// Offsets, field positions, reset values and sizes of the debug trigger block
`ifndef DTB_PARAMS_SVH
`define DTB_PARAMS_SVH

// Register byte offsets
`define DTB_OFF_CONTROL 8'h00
`define DTB_OFF_TRIGGER 8'h04
`define DTB_OFF_STATUS 8'h08
`define DTB_OFF_COMP_A 8'h0C
`define DTB_OFF_COMP_B 8'h10
`define DTB_OFF_CAPT_INDEX 8'h14
`define DTB_OFF_CAPT_DATA 8'h18

// Control register fields
`define DTB_CTL_ENABLE 7
`define DTB_CTL_ARM 6
`define DTB_CTL_TAG 5
`define DTB_CTL_BRK 4
`define DTB_CTL_A_DIR_EN 3
`define DTB_CTL_A_DIR 2
`define DTB_CTL_B_DIR_EN 1
`define DTB_CTL_B_DIR 0

// Trigger register fields
`define DTB_TRG_QUAL 7
`define DTB_TRG_BEGIN 6
`define DTB_TRG_MODE_HI 3

// Status register fields
`define DTB_STS_A_FLAG 7
`define DTB_STS_B_FLAG 6
`define DTB_STS_ARMED 5

// Reset values
`define DTB_RST_CONTROL 8'h00
`define DTB_RST_TRIGGER 8'h00
`define DTB_RST_COMP 16'h0000

// Capture buffer and queue sizes
`define DTB_BUF_DEPTH 8
`define DTB_FULL_COUNT 4'h8
`define DTB_QUEUE_DEPTH 3

// Opcodes handed to the core; values are arbitrary
`define DTB_BG_OPCODE 8'h5A
`define DTB_SWI_OPCODE 8'hA5

`endif

/* logic/dtb_pkg.sv */
// Types of the debug trigger block
package dtb_pkg;

   typedef enum logic [3:0] {
      MODE_A_ONLY = 4'h0,
      MODE_A_OR_B = 4'h1,
      MODE_A_THEN_B = 4'h2,
      MODE_EVENT_B = 4'h3,
      MODE_A_THEN_EVENT_B = 4'h4,
      MODE_A_AND_B_DATA = 4'h5,
      MODE_A_AND_NOT_B_DATA = 4'h6,
      MODE_INSIDE = 4'h7,
      MODE_OUTSIDE = 4'h8
   } dtb_mode_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_ARMED = 2'h1,
      ST_CAPTURE = 2'h2
   } dtb_state_t;

   typedef struct packed {
      logic valid;
      logic read;
      logic [15:0] addr;
      logic [7:0] rdata;
      logic [7:0] wdata;
   } dtb_bus_t;

   typedef struct packed {
      logic fetch;
      logic exec;
      logic flush;
   } dtb_queue_t;

   typedef struct packed {
      logic tag;
      logic force_req;
      logic [7:0] opcode;
   } dtb_break_t;

endpackage

/* logic/dtb_trigger.sv */
// Debug trigger and breakpoint logic with APB register slave
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/10ps
`include "dtb_params.svh"

module dtb_trigger (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Processor bus and instruction queue
   input wire dtb_pkg::dtb_bus_t bus_in,
   input wire dtb_pkg::dtb_queue_t queue_in,
   input wire logic [15:0] cof_addr_in,
   input wire logic cof_valid_in,
   // Serial debug controller
   input wire logic bdc_access_in,
   input wire logic background_permit_in,
   // Breakpoint requests to the core
   output dtb_pkg::dtb_break_t break_out
);

   logic [7:0] debug_control_reg;
   logic [7:0] trigger_control_reg;
   logic [15:0] comp_a_reg;
   logic [15:0] comp_b_reg;
   logic [2:0] capt_index_reg;
   logic comp_a_match_flag_reg;
   logic comp_b_match_flag_reg;
   logic [3:0] stored_word_count_reg;
   logic [2:0] wptr_reg;
   logic a_seen_reg;
   logic [31:0] prdata_reg;
   logic [15:0] buf_reg [`DTB_BUF_DEPTH];
   dtb_pkg::dtb_state_t state_reg;
   dtb_pkg::dtb_break_t break_reg;
   logic [`DTB_QUEUE_DEPTH-1:0] trk_bits_reg [2];
   logic [1:0] trk_cnt_reg [2];
   logic [`DTB_QUEUE_DEPTH-1:0] trk_bits_next [2];
   logic [1:0] trk_cnt_next [2];

   // APB decode
   logic wr_en;
   logic rd_setup;
   logic mapped;
   logic ctl_write;
   logic arm_start;
   logic run_stop;
   assign wr_en = psel_in && penable_in && pwrite_in;
   assign rd_setup = psel_in && !penable_in && !pwrite_in;
   assign mapped = paddr_in inside {`DTB_OFF_CONTROL, `DTB_OFF_TRIGGER, `DTB_OFF_STATUS, `DTB_OFF_COMP_A,
                                    `DTB_OFF_COMP_B, `DTB_OFF_CAPT_INDEX, `DTB_OFF_CAPT_DATA};
   assign pready_out = 1'b1;
   assign pslverr_out = psel_in && penable_in && !mapped;
   assign prdata_out = prdata_reg;
   assign ctl_write = wr_en && (paddr_in == `DTB_OFF_CONTROL);
   assign arm_start = ctl_write && pwdata_in[`DTB_CTL_ARM] && pwdata_in[`DTB_CTL_ENABLE];
   assign run_stop = ctl_write && !(pwdata_in[`DTB_CTL_ARM] && pwdata_in[`DTB_CTL_ENABLE]);

   // Control field views
   dtb_pkg::dtb_mode_t mode;
   logic module_enable;
   logic tag_select;
   logic breakpoint_enable;
   logic comp_a_dir_enable;
   logic comp_a_dir_value;
   logic comp_b_dir_enable;
   logic comp_b_dir_value;
   logic opcode_qualify_select;
   logic begin_select;
   logic event_mode;
   logic full_mode;
   logic begin_type;
   assign mode = dtb_pkg::dtb_mode_t'(trigger_control_reg[`DTB_TRG_MODE_HI:0]);
   assign module_enable = debug_control_reg[`DTB_CTL_ENABLE];
   assign tag_select = debug_control_reg[`DTB_CTL_TAG];
   assign breakpoint_enable = debug_control_reg[`DTB_CTL_BRK];
   assign comp_a_dir_enable = debug_control_reg[`DTB_CTL_A_DIR_EN];
   assign comp_a_dir_value = debug_control_reg[`DTB_CTL_A_DIR];
   assign comp_b_dir_enable = debug_control_reg[`DTB_CTL_B_DIR_EN];
   assign comp_b_dir_value = debug_control_reg[`DTB_CTL_B_DIR];
   assign opcode_qualify_select = trigger_control_reg[`DTB_TRG_QUAL];
   assign begin_select = trigger_control_reg[`DTB_TRG_BEGIN];
   assign event_mode = (mode == dtb_pkg::MODE_EVENT_B) || (mode == dtb_pkg::MODE_A_THEN_EVENT_B);
   assign full_mode = (mode == dtb_pkg::MODE_A_AND_B_DATA) || (mode == dtb_pkg::MODE_A_AND_NOT_B_DATA);
   assign begin_type = begin_select || event_mode;

   // Comparators
   logic cmp_on;
   logic dir_a_ok;
   logic dir_b_ok;
   logic a_hit;
   logic b_hit;
   logic [7:0] cmp_data;
   logic b_data;
   logic prim_a;
   assign cmp_on = bus_in.valid && module_enable && !bdc_access_in;
   assign dir_a_ok = !comp_a_dir_enable || (bus_in.read == comp_a_dir_value);
   assign dir_b_ok = !comp_b_dir_enable || (bus_in.read == comp_b_dir_value);
   assign a_hit = cmp_on && (bus_in.addr == comp_a_reg) && dir_a_ok;
   assign b_hit = cmp_on && (bus_in.addr == comp_b_reg) && dir_b_ok;
   assign cmp_data = (comp_a_dir_enable && !comp_a_dir_value) ? bus_in.wdata : bus_in.rdata;
   assign b_data = (cmp_data == comp_b_reg[7:0]);

   always_comb begin
      case (mode)
         dtb_pkg::MODE_A_AND_B_DATA: prim_a = a_hit && b_data;
         dtb_pkg::MODE_A_AND_NOT_B_DATA: prim_a = a_hit && !b_data;
         dtb_pkg::MODE_INSIDE: prim_a = cmp_on && dir_a_ok && (bus_in.addr >= comp_a_reg) &&
                                       (bus_in.addr <= comp_b_reg);
         dtb_pkg::MODE_OUTSIDE: prim_a = cmp_on && dir_a_ok && ((bus_in.addr < comp_a_reg) ||
                                        (bus_in.addr > comp_b_reg));
         default: prim_a = a_hit;
      endcase
   end

   // Opcode tracking, one queue per comparator
   logic [1:0] trk_mark;
   logic [1:0] trk_hit;
   assign trk_mark = {b_hit, prim_a} & {2{queue_in.fetch}};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_track
         logic [1:0] cnt_tmp;
         logic [`DTB_QUEUE_DEPTH-1:0] bits_tmp;
         assign trk_hit[gi] = queue_in.exec && (trk_cnt_reg[gi] != 2'h0) && trk_bits_reg[gi][0];
         always_comb begin
            bits_tmp = trk_bits_reg[gi];
            cnt_tmp = trk_cnt_reg[gi];
            if (queue_in.exec && (cnt_tmp != 2'h0)) begin
               bits_tmp = bits_tmp >> 1;
               cnt_tmp = cnt_tmp - 2'h1;
            end
            if (queue_in.flush) begin
               bits_tmp = '0;
               cnt_tmp = 2'h0;
            end
            if (queue_in.fetch && (cnt_tmp < 2'(`DTB_QUEUE_DEPTH))) begin
               bits_tmp[cnt_tmp] = trk_mark[gi];
               cnt_tmp = cnt_tmp + 2'h1;
            end
            trk_bits_next[gi] = bits_tmp;
            trk_cnt_next[gi] = cnt_tmp;
         end
         always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
               trk_bits_reg[gi] <= '0;
               trk_cnt_reg[gi] <= 2'h0;
            end else begin
               trk_bits_reg[gi] <= trk_bits_next[gi];
               trk_cnt_reg[gi] <= trk_cnt_next[gi];
            end
         end
      end
   endgenerate

   // Trigger selection per mode
   function automatic logic trig_of(input dtb_pkg::dtb_mode_t m, input logic a, input logic b,
                                    input logic seen);
      case (m)
         dtb_pkg::MODE_A_ONLY: trig_of = a;
         dtb_pkg::MODE_A_OR_B: trig_of = a || b;
         dtb_pkg::MODE_A_THEN_B: trig_of = b && seen;
         dtb_pkg::MODE_EVENT_B: trig_of = b;
         dtb_pkg::MODE_A_THEN_EVENT_B: trig_of = b && seen;
         dtb_pkg::MODE_A_AND_B_DATA, dtb_pkg::MODE_A_AND_NOT_B_DATA, dtb_pkg::MODE_INSIDE,
            dtb_pkg::MODE_OUTSIDE: trig_of = a;
         default: trig_of = 1'b0;
      endcase
   endfunction

   logic qa;
   logic qb;
   logic armed;
   logic trigger;
   logic tag_cond;
   assign qa = opcode_qualify_select ? (trk_hit[0] && !bdc_access_in) : prim_a;
   assign qb = opcode_qualify_select ? (trk_hit[1] && !bdc_access_in) : b_hit;
   assign armed = (state_reg != dtb_pkg::ST_IDLE);
   assign trigger = armed && trig_of(mode, qa, qb, a_seen_reg);
   assign tag_cond = armed && queue_in.fetch && trig_of(mode, full_mode ? a_hit : prim_a, b_hit, a_seen_reg);

   // Register writes
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         debug_control_reg <= `DTB_RST_CONTROL;
         trigger_control_reg <= `DTB_RST_TRIGGER;
         comp_a_reg <= `DTB_RST_COMP;
         comp_b_reg <= `DTB_RST_COMP;
         capt_index_reg <= 3'h0;
      end else if (wr_en) begin
         case (paddr_in)
            `DTB_OFF_CONTROL: debug_control_reg <= pwdata_in[7:0];
            `DTB_OFF_TRIGGER: trigger_control_reg <= pwdata_in[7:0];
            `DTB_OFF_COMP_A: comp_a_reg <= pwdata_in[15:0];
            `DTB_OFF_COMP_B: comp_b_reg <= pwdata_in[15:0];
            `DTB_OFF_CAPT_INDEX: capt_index_reg <= pwdata_in[2:0];
            default: ;
         endcase
      end
   end

   // Read data, captured in the setup cycle
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         prdata_reg <= 32'h0000_0000;
      end else if (rd_setup) begin
         case (paddr_in)
            `DTB_OFF_CONTROL: prdata_reg <= {24'h00_0000, debug_control_reg};
            `DTB_OFF_TRIGGER: prdata_reg <= {24'h00_0000, trigger_control_reg};
            `DTB_OFF_STATUS: prdata_reg <= {24'h00_0000, comp_a_match_flag_reg, comp_b_match_flag_reg, armed,
                                            1'b0, stored_word_count_reg};
            `DTB_OFF_COMP_A: prdata_reg <= {16'h0000, comp_a_reg};
            `DTB_OFF_COMP_B: prdata_reg <= {16'h0000, comp_b_reg};
            `DTB_OFF_CAPT_INDEX: prdata_reg <= {29'h0000_0000, capt_index_reg};
            `DTB_OFF_CAPT_DATA: prdata_reg <= {16'h0000, buf_reg[capt_index_reg]};
            default: prdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   // Run sequencer
   logic store_en;
   logic [15:0] store_word;
   logic buf_full_next;
   assign store_word = event_mode ? {8'h00, cmp_data} : cof_addr_in;
   always_comb begin
      store_en = 1'b0;
      if (event_mode) begin
         store_en = (state_reg == dtb_pkg::ST_ARMED) && trigger;
      end else if (cof_valid_in) begin
         store_en = (state_reg == dtb_pkg::ST_CAPTURE) ||
                    ((state_reg == dtb_pkg::ST_ARMED) && !begin_type);
      end
   end
   assign buf_full_next = store_en && (stored_word_count_reg == `DTB_FULL_COUNT - 4'h1);

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg <= dtb_pkg::ST_IDLE;
      end else if (arm_start) begin
         state_reg <= dtb_pkg::ST_ARMED;
      end else if (run_stop) begin
         state_reg <= dtb_pkg::ST_IDLE;
      end else begin
         case (state_reg)
            dtb_pkg::ST_ARMED: begin
               if (event_mode) begin
                  if (buf_full_next) begin
                     state_reg <= dtb_pkg::ST_IDLE;
                  end
               end else if (trigger) begin
                  state_reg <= begin_type ? dtb_pkg::ST_CAPTURE : dtb_pkg::ST_IDLE;
               end
            end
            dtb_pkg::ST_CAPTURE: begin
               if (buf_full_next) begin
                  state_reg <= dtb_pkg::ST_IDLE;
               end
            end
            default: state_reg <= dtb_pkg::ST_IDLE;
         endcase
      end
   end

   // Capture buffer, pointer and count
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         wptr_reg <= 3'h0;
         stored_word_count_reg <= 4'h0;
      end else if (arm_start) begin
         wptr_reg <= 3'h0;
         stored_word_count_reg <= 4'h0;
      end else if (store_en) begin
         wptr_reg <= wptr_reg + 3'h1;
         if (stored_word_count_reg != `DTB_FULL_COUNT) begin
            stored_word_count_reg <= stored_word_count_reg + 4'h1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (store_en) begin
         buf_reg[wptr_reg] <= store_word;
      end
   end

   // Match flags and sequence memory
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         comp_a_match_flag_reg <= 1'b0;
         comp_b_match_flag_reg <= 1'b0;
         a_seen_reg <= 1'b0;
      end else if (arm_start) begin
         comp_a_match_flag_reg <= 1'b0;
         comp_b_match_flag_reg <= 1'b0;
         a_seen_reg <= 1'b0;
      end else if (armed) begin
         if (qa) begin
            comp_a_match_flag_reg <= 1'b1;
            a_seen_reg <= 1'b1;
         end
         if (qb) begin
            comp_b_match_flag_reg <= 1'b1;
         end
      end
   end

   // Breakpoint requests
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         break_reg <= '0;
      end else begin
         break_reg.tag <= breakpoint_enable && tag_select && tag_cond;
         break_reg.force_req <= breakpoint_enable && !tag_select && trigger;
         break_reg.opcode <= background_permit_in ? `DTB_BG_OPCODE : `DTB_SWI_OPCODE;
      end
   end
   assign break_out = break_reg;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   a_arm_clears_status: assert property (arm_start |=> armed && stored_word_count_reg == 4'h0 &&
      !comp_a_match_flag_reg && !comp_b_match_flag_reg) else $error("arm did not reset status");
   a_stop_disarms: assert property (run_stop |=> !armed) else $error("stop did not disarm");
   a_end_trigger_ends: assert property ((state_reg == dtb_pkg::ST_ARMED) && !begin_type && trigger &&
      !ctl_write |=> state_reg == dtb_pkg::ST_IDLE) else $error("end trigger did not end run");
   a_capture_not_full: assert property ((state_reg == dtb_pkg::ST_CAPTURE) |->
      stored_word_count_reg < `DTB_FULL_COUNT) else $error("capture continued when full");
   a_force_cause: assert property (break_out.force_req |-> $past(trigger) && $past(breakpoint_enable) &&
      !$past(tag_select)) else $error("force break without trigger");
   a_tag_on_fetch: assert property (break_out.tag |-> $past(queue_in.fetch) && $past(armed))
      else $error("tag break not tied to a fetch");
   a_bdc_quiet: assert property (bdc_access_in && !opcode_qualify_select |-> !a_hit && !b_hit && !trigger)
      else $error("comparator active during debug access");
   a_opcode_permit: assert property (!rst_in |=> break_out.opcode == ($past(background_permit_in) ?
      `DTB_BG_OPCODE : `DTB_SWI_OPCODE)) else $error("wrong break opcode");
   a_event_low_byte: assert property (store_en && event_mode |=> buf_reg[$past(wptr_reg)][15:8] == 8'h00)
      else $error("event store used high byte");
   a_dir_check: assert property (armed && (mode == dtb_pkg::MODE_A_ONLY) && !opcode_qualify_select &&
      comp_a_dir_enable && (bus_in.read != comp_a_dir_value) |-> !trigger)
      else $error("direction qualification ignored");
   a_flush_drops: assert property (queue_in.flush && !queue_in.fetch |=> trk_cnt_reg[0] == 2'h0 &&
      trk_cnt_reg[1] == 2'h0) else $error("flush kept tags");

   c_begin_full: cover property ((state_reg == dtb_pkg::ST_CAPTURE) ##1 (state_reg == dtb_pkg::ST_IDLE));
   c_end_trigger: cover property ((state_reg == dtb_pkg::ST_ARMED) && !begin_type && trigger);
   c_tag_break: cover property (break_out.tag);
   c_event_store: cover property (store_en && event_mode);

endmodule

/* sim/dtb_core_model.sv */
// Processor core model: bus cycles, queue events, break request counting
`timescale 1ns/10ps
module dtb_core_model (
   // Clock
   input wire logic clk_in,
   // Break requests from the debug block
   input wire dtb_pkg::dtb_break_t break_in,
   // Bus, queue and flow to the debug block
   output dtb_pkg::dtb_bus_t bus_out,
   output dtb_pkg::dtb_queue_t queue_out,
   output logic [15:0] cof_addr_out,
   output logic cof_valid_out
);
   int n_force = 0;
   int n_tag = 0;
   logic [7:0] last_op = 8'h00;
   initial begin
      bus_out = '0;
      queue_out = '0;
      cof_addr_out = 16'h0000;
      cof_valid_out = 1'b0;
   end
   // Core takes requests and the opcode it runs instead
   always @(posedge clk_in) begin
      if (break_in.force_req === 1'b1) begin
         n_force++;
         last_op = break_in.opcode;
      end
      if (break_in.tag === 1'b1) begin
         n_tag++;
         last_op = break_in.opcode;
      end
   end
   // One bus cycle; released lines show inverted values
   task automatic cycle(input logic rd, input logic [15:0] a, input logic [7:0] rdat, wdat,
                        input dtb_pkg::dtb_queue_t q);
      @(posedge clk_in);
      bus_out <= '{1'b1, rd, a, rdat, wdat};
      queue_out <= q;
      @(posedge clk_in);
      bus_out <= '{1'b0, ~rd, ~a, ~rdat, ~wdat};
      queue_out <= '0;
   endtask
   task automatic pulse(input dtb_pkg::dtb_queue_t q);
      @(posedge clk_in);
      queue_out <= q;
      @(posedge clk_in);
      queue_out <= '0;
   endtask
   task automatic cof(input logic [15:0] a);
      @(posedge clk_in);
      cof_addr_out <= a;
      cof_valid_out <= 1'b1;
      @(posedge clk_in);
      cof_addr_out <= ~a;
      cof_valid_out <= 1'b0;
   endtask
endmodule

/* sim/test_dtb_trigger.sv */
// Testbench of the debug trigger block
`timescale 1ns/10ps
`include "dtb_params.svh"
module test_dtb_trigger;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, bdc = 1'b0, permit = 1'b1;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err;
   dtb_pkg::dtb_bus_t bus;
   dtb_pkg::dtb_queue_t que;
   dtb_pkg::dtb_break_t brk_o;
   logic [15:0] cof_a;
   logic cof_v;
   int n_errors = 0, n_compared = 0, f0 = 0, t0 = 0, cyc = 0;
   logic [15:0] ad [4] = '{16'h0FFF, 16'h1000, 16'h2000, 16'h2001};
   logic [3:0] in_range = 4'b0110;
   always #5 clk_in = ~clk_in;
   dtb_trigger u_dtb_trigger (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .bus_in(bus), .queue_in(que), .cof_addr_in(cof_a), .cof_valid_in(cof_v),
      .bdc_access_in(bdc), .background_permit_in(permit), .break_out(brk_o));
   dtb_core_model u_dtb_core_model (.clk_in(clk_in), .break_in(brk_o), .bus_out(bus), .queue_out(que),
      .cof_addr_out(cof_a), .cof_valid_out(cof_v));
   task automatic report_and_stop;
      if (n_errors == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   always @(posedge clk_in) begin
      cyc++;
      if (cyc > 8000) begin
         n_errors++;
         report_and_stop;
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      do @(posedge clk_in); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic status(input logic [31:0] e);
      apb(1'b0, `DTB_OFF_STATUS, 32'h0);
      chk("status", rd, e);
   endtask
   task automatic arm(input logic [7:0] ctl, trigger_mode_field, input logic [15:0] b);
      apb(1'b1, `DTB_OFF_TRIGGER, {24'h0, trigger_mode_field});
      apb(1'b1, `DTB_OFF_COMP_A, 32'h1000);
      apb(1'b1, `DTB_OFF_COMP_B, {16'h0, b});
      apb(1'b1, `DTB_OFF_CONTROL, {24'h0, ctl});
   endtask
   task automatic brk(input logic [1:0] e);
      repeat (3) @(posedge clk_in);
      chk("force", 32'(u_dtb_core_model.n_force - f0), {31'h0, e[1]});
      chk("tag", 32'(u_dtb_core_model.n_tag - t0), {31'h0, e[0]});
      f0 = u_dtb_core_model.n_force;
      t0 = u_dtb_core_model.n_tag;
   endtask
   task automatic try(input logic [7:0] ctl, trigger_mode_field, input logic [15:0] b, a, input logic r,
                      input logic [7:0] rdat, wdat, input logic fe, input logic [1:0] e);
      arm(ctl, trigger_mode_field, b);
      u_dtb_core_model.cycle(r, a, rdat, wdat, '{fe, 1'b0, 1'b0});
      brk(e);
   endtask
   initial begin
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      apb(1'b0, 8'h1C, 32'h0);
      chk("unmapped", {rd[30:0], err}, 32'h1);
      apb(1'b1, `DTB_OFF_TRIGGER, 32'h48);
      apb(1'b0, `DTB_OFF_TRIGGER, 32'h0);
      chk("trigger", rd, 32'h48);
      for (int p = 0; p < 2; p++) begin
         permit <= p[0];
         try(8'hD0, 8'h00, 16'hFFFF, 16'h1000, 1'b0, 8'h00, 8'h00, 1'b0, 2'b10);
         chk("opcode", {24'h0, u_dtb_core_model.last_op}, p ? `DTB_BG_OPCODE : `DTB_SWI_OPCODE);
         status(32'h80);
      end
      try(8'hD0, 8'h01, 16'h2000, 16'h2000, 1'b1, 8'h00, 8'h00, 1'b0, 2'b10);
      try(8'hD0, 8'h00, 16'h2000, 16'h2000, 1'b1, 8'h00, 8'h00, 1'b0, 2'b00);
      try(8'hD0, 8'h09, 16'h2000, 16'h1000, 1'b1, 8'h00, 8'h00, 1'b0, 2'b00);
      for (int i = 0; i < 4; i++) begin
         try(8'hD0, 8'h07, 16'h2000, ad[i], 1'b1, 8'h00, 8'h00, 1'b0, {in_range[i], 1'b0});
         try(8'hD0, 8'h08, 16'h2000, ad[i], 1'b1, 8'h00, 8'h00, 1'b0, {~in_range[i], 1'b0});
      end
      try(8'hDC, 8'h00, 16'hFFFF, 16'h1000, 1'b0, 8'h00, 8'h00, 1'b0, 2'b00);
      try(8'hDC, 8'h00, 16'hFFFF, 16'h1000, 1'b1, 8'h00, 8'h00, 1'b0, 2'b10);
      try(8'hD8, 8'h00, 16'hFFFF, 16'h1000, 1'b1, 8'h00, 8'h00, 1'b0, 2'b00);
      bdc <= 1'b1;
      try(8'hD0, 8'h00, 16'hFFFF, 16'h1000, 1'b1, 8'h00, 8'h00, 1'b0, 2'b00);
      bdc <= 1'b0;
      try(8'hD8, 8'h05, 16'h0077, 16'h1000, 1'b0, 8'h00, 8'h77, 1'b0, 2'b10);
      try(8'hD8, 8'h05, 16'h0077, 16'h1000, 1'b0, 8'h77, 8'h00, 1'b0, 2'b00);
      try(8'hD0, 8'h05, 16'h0077, 16'h1000, 1'b1, 8'h77, 8'h00, 1'b0, 2'b10);
      try(8'hD8, 8'h05, 16'h0077, 16'h1001, 1'b0, 8'h00, 8'h77, 1'b0, 2'b00);
      try(8'hD8, 8'h06, 16'h0077, 16'h1000, 1'b0, 8'h00, 8'h77, 1'b0, 2'b00);
      try(8'hD8, 8'h06, 16'h0077, 16'h1000, 1'b0, 8'h77, 8'h00, 1'b0, 2'b10);
      try(8'hF0, 8'h05, 16'h0077, 16'h1000, 1'b1, 8'h00, 8'h00, 1'b1, 2'b01);
      try(8'hF0, 8'h00, 16'hFFFF, 16'h1000, 1'b1, 8'h00, 8'h00, 1'b1, 2'b01);
      try(8'hC0, 8'h00, 16'hFFFF, 16'h1000, 1'b1, 8'h00, 8'h00, 1'b0, 2'b00);
      u_dtb_core_model.pulse('{1'b0, 1'b0, 1'b1});
      try(8'hD0, 8'h80, 16'hFFFF, 16'h1000, 1'b1, 8'h00, 8'h00, 1'b1, 2'b00);
      u_dtb_core_model.pulse('{1'b0, 1'b1, 1'b0});
      brk(2'b10);
      try(8'hD0, 8'h80, 16'hFFFF, 16'h1000, 1'b1, 8'h00, 8'h00, 1'b1, 2'b00);
      u_dtb_core_model.pulse('{1'b0, 1'b0, 1'b1});
      u_dtb_core_model.pulse('{1'b0, 1'b1, 1'b0});
      brk(2'b00);
      try(8'hD0, 8'h81, 16'h2000, 16'h2000, 1'b1, 8'h00, 8'h00, 1'b1, 2'b00);
      u_dtb_core_model.pulse('{1'b0, 1'b1, 1'b0});
      brk(2'b10);
      arm(8'hD0, 8'h02, 16'h2000);
      u_dtb_core_model.cycle(1'b1, 16'h2000, 8'h00, 8'h00, '0);
      brk(2'b00);
      u_dtb_core_model.cycle(1'b1, 16'h1000, 8'h00, 8'h00, '0);
      u_dtb_core_model.cycle(1'b1, 16'h2000, 8'h00, 8'h00, '0);
      brk(2'b10);
      arm(8'hC0, 8'h40, 16'hFFFF);
      u_dtb_core_model.cof(16'h5555);
      u_dtb_core_model.cycle(1'b1, 16'h1000, 8'h00, 8'h00, '0);
      repeat (3) @(posedge clk_in);
      for (int i = 0; i < 7; i++) u_dtb_core_model.cof(16'h3000 + 16'(i));
      status(32'hA7);
      u_dtb_core_model.cof(16'h3007);
      status(32'h88);
      arm(8'hC0, 8'h00, 16'hFFFF);
      for (int i = 0; i < 3; i++) u_dtb_core_model.cof(16'h4000 + 16'(i));
      u_dtb_core_model.cycle(1'b1, 16'h1000, 8'h00, 8'h00, '0);
      status(32'h83);
      arm(8'hC0, 8'h03, 16'h2000);
      for (int i = 0; i < 7; i++) u_dtb_core_model.cycle(1'b1, 16'h2000, 8'h10 + 8'(i), 8'h00, '0);
      status(32'h67);
      u_dtb_core_model.cycle(1'b1, 16'h2000, 8'h17, 8'h00, '0);
      status(32'h48);
      apb(1'b1, `DTB_OFF_CAPT_INDEX, 32'h0);
      apb(1'b0, `DTB_OFF_CAPT_DATA, 32'h0);
      chk("capture", rd, 32'h10);
      arm(8'hC0, 8'h04, 16'h2000);
      u_dtb_core_model.cycle(1'b1, 16'h2000, 8'h00, 8'h00, '0);
      status(32'h60);
      u_dtb_core_model.cycle(1'b1, 16'h1000, 8'h00, 8'h00, '0);
      u_dtb_core_model.cycle(1'b1, 16'h2000, 8'h00, 8'h00, '0);
      apb(1'b0, `DTB_OFF_STATUS, 32'h0);
      chk("count", 32'(u_dtb_core_model.n_force - f0), 32'h0);
      chk("seq", {28'h0, rd[3:0]}, 32'h1);
      arm(8'hC0, 8'h00, 16'hFFFF);
      status(32'h20);
      apb(1'b1, `DTB_OFF_CONTROL, 32'h40);
      status(32'h00);
      arm(8'hC0, 8'h00, 16'hFFFF);
      apb(1'b1, `DTB_OFF_CONTROL, 32'h80);
      status(32'h00);
      report_and_stop;
   end
endmodule
